// ===== pkg/tpw_regs.svh
// Register offsets, field positions, reset values and codes of the timer/PWM block
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// ==========================================================
// Word indices (byte address bits 6:2)
`define TPW_ADDR_W 7
`define TPW_IDX_MODE0 5'h00
`define TPW_IDX_MATCH0 5'h04
`define TPW_IDX_MODE4 5'h08
`define TPW_IDX_MATCH4_LO 5'h09
`define TPW_IDX_MATCH4_HI 5'h0a
`define TPW_IDX_PORT_SEL 5'h0b
`define TPW_IDX_EDGE_SEL 5'h0c
`define TPW_IDX_EDGE_SEL4 5'h0d
`define TPW_IDX_FLAGS 5'h0e
`define TPW_IDX_PWM_PERIOD0 5'h0f
`define TPW_IDX_PWM_DUTY0 5'h10
`define TPW_IDX_PWM_EXT0 5'h11
`define TPW_IDX_PWM_STRIDE 5'h03

// ==========================================================
// Field positions
`define TPW_PSEL_PWM0 0
`define TPW_PSEL_PWM1 1
`define TPW_EXT_PERIOD_HI 3
`define TPW_EXT_PERIOD_LO 2
`define TPW_EXT_DUTY_HI 1
`define TPW_EXT_DUTY_LO 0

// ==========================================================
// Reset values and codes
`define TPW_RST_BYTE 8'h00
`define TPW_CLKSEL_EXT 3'h7
`define TPW_EDGE_FALL 2'h0
`define TPW_EDGE_RISE 2'h1
`define TPW_EDGE_BOTH 2'h2
`define TPW_DUTY_FORCE_OFF 10'h100
`define TPW_PWM_CNT_START 10'h001
`define TPW_PRESCALE_W 7

`endif

// ===== pkg/tpw_pkg.sv
// Types shared by the timer/PWM block
package tpw_pkg;

  // ==========================================================
  // Per-timer mode register layout, msb first
  typedef struct packed {
    logic duty_level_invert;        // duty_level_invert
    logic pwm_en;     // first_pwm_enable (odd timers)
    logic cascade;    // cascade_pair_enable (odd timers)
    logic cap_en;     // capture enable
    logic run;        // count enable
    logic [2:0] clksel;
  } tpw_mode_t;

  // Configuration handed to one PWM channel
  typedef struct packed {
    logic [9:0] period;
    logic [9:0] duty_hold;
    logic duty_level_invert;
  } tpw_pwm_cfg_t;

  // Bus slave phase
  typedef enum logic {BUS_IDLE, BUS_DONE} tpw_bus_st_t;

endpackage

// ===== rtl/tpw_pwm_chan.sv
// One 10-bit double-buffered PWM channel
`timescale 1ns/1ps
`include "tpw_regs.svh"

module tpw_pwm_chan #(
  parameter int W = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_tick,
  input wire tpw_pkg::tpw_pwm_cfg_t i_cfg,
  output logic o_pwm
);
  import tpw_pkg::*;

  logic [W-1:0] cnt;
  logic [W-1:0] duty_act;
  logic wrap;
  logic raw;

  // ==========================================================
  // Counter runs 1..period so a cycle lasts period ticks
  // period and duty in source ticks
  assign wrap = (cnt >= i_cfg.period);

  // duty moves to active stage only at period match or while reset or disabled
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_enable) begin
      cnt <= `TPW_PWM_CNT_START;
      duty_act <= i_cfg.duty_hold;
    end else if (i_tick) begin
      if (wrap) begin
        cnt <= `TPW_PWM_CNT_START;
        duty_act <= i_cfg.duty_hold;  // new duty after current period
      end else begin
        cnt <= cnt + W'(1);
      end
    end
  end

  // duty 100h holds the opposite level
  // duty equal to period keeps the duty level all the time
  assign raw = (duty_act != `TPW_DUTY_FORCE_OFF) && (cnt <= duty_act);

  // polarity picks the level of the duty portion
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pwm <= 1'b0;
    end else begin
      o_pwm <= i_enable ? (i_cfg.duty_level_invert ? raw : ~raw) : 1'b0;
    end
  end

endmodule

// ===== rtl/tpw_top.sv
// Cascaded timers with 8/16-bit capture and two 10-bit PWM outputs
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tpw_regs.svh"

// How it works
// - wide capture behaves as byte capture but on the 16-bit pair value.
// - a wide pair counts from the lower timer's three-bit clock select.
// - timer 4 takes its count source from its own clock select.
// - two PWM outputs of up to 10 bits share timers 1 and 3.
// - period is period register plus extension bits 3:2.
// - duty is duty register plus extension bits 1:0.
// - duty is double-buffered, loaded at period match.
// - period and active time are the 10-bit values times source ticks.
// - second channel repeats the scheme with its own registers.
// - polarity bit selects the level of the duty portion.
// - duty equal to period gives constant duty-level output.
// - duty 100h gives constant opposite-level output.
// - duty changes wait for period end; period change keeps duty time.
// - trigger edge copies timer into capture, clears and restarts it.
// - capture shares the match address and is read in capture mode.
// - match flag still sets in capture mode.
module tpw_top (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [`TPW_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [4:0] i_capture_trigger_input,
  input wire logic [2:0] i_ext_count,
  output logic [4:0] o_match_flag,
  output logic [1:0] o_pwm_pin,
  output logic [1:0] o_pwm_pin_oe
);
  import tpw_pkg::*;

  // ==========================================================
  // Bus slave
  tpw_bus_st_t bus_st;
  tpw_bus_st_t next_bus_st;
  logic req;
  logic acc_wr;
  logic [4:0] idx;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  // One wait state: request seen, then answered on the next edge
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req && (bus_st == BUS_IDLE);
  assign acc_wr = i_avs_write && (bus_st == BUS_DONE);
  assign idx = i_avs_address[`TPW_ADDR_W-1:2];
  assign wbyte = i_avs_writedata[7:0];
  assign next_bus_st = (req && bus_st == BUS_IDLE) ? BUS_DONE : BUS_IDLE;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_st <= BUS_IDLE;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_st <= next_bus_st;
      if (i_avs_read && bus_st == BUS_IDLE) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Software registers
  tpw_mode_t mode [0:4];
  logic [7:0] match [0:3];
  logic [7:0] cap [0:3];
  logic [15:0] match4;
  logic [15:0] cap4;
  logic [7:0] port_sel;
  logic [7:0] edge_sel;
  logic [1:0] edge_sel4;
  logic [4:0] flags;
  logic [4:0] flag_set;
  logic [7:0] pwm_period [0:1];
  logic [7:0] pwm_duty [0:1];
  logic [3:0] pwm_ext [0:1];

  // Write strobes for simple byte registers
  logic wr_mode4;
  logic wr_m4lo;
  logic wr_m4hi;
  assign wr_mode4 = acc_wr && idx == `TPW_IDX_MODE4;
  assign wr_m4lo = acc_wr && idx == `TPW_IDX_MATCH4_LO;
  assign wr_m4hi = acc_wr && idx == `TPW_IDX_MATCH4_HI;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode[4] <= tpw_mode_t'(`TPW_RST_BYTE);
      match4 <= {`TPW_RST_BYTE, `TPW_RST_BYTE};
      port_sel <= `TPW_RST_BYTE;
      edge_sel <= `TPW_RST_BYTE;
      edge_sel4 <= `TPW_EDGE_FALL;
    end else begin
      if (wr_mode4) mode[4] <= tpw_mode_t'(wbyte);
      if (wr_m4lo) match4[7:0] <= wbyte;
      if (wr_m4hi) match4[15:8] <= wbyte;
      if (acc_wr && idx == `TPW_IDX_PORT_SEL) port_sel <= wbyte;
      if (acc_wr && idx == `TPW_IDX_EDGE_SEL) edge_sel <= wbyte;
      if (acc_wr && idx == `TPW_IDX_EDGE_SEL4) edge_sel4 <= wbyte[1:0];
    end
  end

  // Sticky match flags; write one clears, a new match in the same cycle wins
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flags <= 5'h00;
    end else begin
      flags <= (flags & ~((acc_wr && idx == `TPW_IDX_FLAGS) ? wbyte[4:0] : 5'h00)) | flag_set;
    end
  end
  assign o_match_flag = flags;

  // ==========================================================
  // Count sources: free prescaler and synchronous external edges
  logic [`TPW_PRESCALE_W-1:0] presc;
  logic [2:0] ext_prev;
  logic [2:0] ext_rise;
  logic [4:0] trg_prev;
  logic [4:0] tick;
  logic [4:0] trg;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      presc <= '0;
      ext_prev <= 3'h0;
      trg_prev <= 5'h00;
    end else begin
      presc <= presc + `TPW_PRESCALE_W'(1);
      ext_prev <= i_ext_count;
      trg_prev <= i_capture_trigger_input;
    end
  end
  assign ext_rise = i_ext_count & ~ext_prev;

  // Divide by 2^(sel+1); only timers 0, 2 and 4 own an external input
  function automatic logic src_tick(input logic [2:0] sel, input logic ext,
                                    input logic has_ext, input logic [`TPW_PRESCALE_W-1:0] p);
    logic [`TPW_PRESCALE_W-1:0] msk;
    msk = `TPW_PRESCALE_W'((8'h02 << sel) - 8'h01);
    if (sel == `TPW_CLKSEL_EXT) begin
      src_tick = has_ext & ext;
    end else begin
      src_tick = ((p & msk) == msk);
    end
  endfunction

  // Edge detect of a trigger per its two-bit select
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    case (sel)
      `TPW_EDGE_FALL: edge_hit = prv & ~cur;
      `TPW_EDGE_RISE: edge_hit = cur & ~prv;
      `TPW_EDGE_BOTH: edge_hit = cur ^ prv;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // timer 4 uses its own select; pairs use lower select
  genvar t;
  generate
    for (t = 0; t < 5; t++) begin : g_src
      localparam logic HAS_EXT = (t % 2) == 0;
      localparam int EXT_I = t / 2;
      assign tick[t] = mode[t].run & src_tick(mode[t].clksel, ext_rise[EXT_I], HAS_EXT, presc);
      assign trg[t] = edge_hit((t == 4) ? edge_sel4 : edge_sel[2*(t%4)+:2],
                               i_capture_trigger_input[t], trg_prev[t]);
    end
  endgenerate

  // ==========================================================
  // Timer pairs 0/1 and 2/3
  logic [7:0] cnt [0:3];
  logic [3:0] cap_mode;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      localparam int LO = 2 * p;
      localparam int HI = 2 * p + 1;
      logic wide;
      logic wcap;
      logic m16;
      logic m_lo;
      logic m_hi;
      logic [7:0] next_lo;
      logic [7:0] next_hi;
      logic [7:0] next_cap_lo;
      logic [7:0] next_cap_hi;
      logic [15:0] inc16;
      logic ev_lo;
      logic ev_hi;

      // pairing decoded from the upper timer's mode bits
      assign wide = mode[HI].cascade & ~mode[HI].pwm_en;
      assign wcap = wide & mode[HI].cap_en;
      assign cap_mode[LO] = wide ? wcap : mode[LO].cap_en;
      assign cap_mode[HI] = wide ? wcap : mode[HI].cap_en;
      assign m16 = {cnt[HI], cnt[LO]} == {match[HI], match[LO]};
      assign m_lo = cnt[LO] == match[LO];
      assign m_hi = cnt[HI] == match[HI];
      assign inc16 = {cnt[HI], cnt[LO]} + 16'h0001;

      // match events set flags whether or not capture is on
      assign ev_lo = tick[LO] & (wide ? m16 : m_lo);
      assign ev_hi = ~wide & ~mode[HI].pwm_en & tick[HI] & m_hi;
      assign flag_set[LO] = ev_lo;
      assign flag_set[HI] = ev_hi;

      always_comb begin
        next_lo = cnt[LO];
        next_hi = cnt[HI];
        next_cap_lo = cap[LO];
        next_cap_hi = cap[HI];
        if (wide) begin
          // same capture flow on the 16-bit value
          if (wcap && trg[LO]) begin
            // each byte to its own capture register, same edge
            next_cap_lo = cnt[LO];
            next_cap_hi = cnt[HI];
            next_lo = 8'h00;
            next_hi = 8'h00;
          end else if (tick[LO]) begin
            next_lo = m16 ? 8'h00 : inc16[7:0];
            next_hi = m16 ? 8'h00 : inc16[15:8];
          end
        end else begin
          // capture, clear and restart on the trigger edge
          if (mode[LO].cap_en && trg[LO]) begin
            next_cap_lo = cnt[LO];
            next_lo = 8'h00;
          end else if (tick[LO]) begin
            next_lo = m_lo ? 8'h00 : cnt[LO] + 8'h01;
          end
          // PWM enable parks the byte timer
          if (mode[HI].pwm_en) begin
            next_hi = 8'h00;
          end else if (mode[HI].cap_en && trg[HI]) begin
            next_cap_hi = cnt[HI];
            next_hi = 8'h00;
          end else if (tick[HI]) begin
            next_hi = m_hi ? 8'h00 : cnt[HI] + 8'h01;
          end
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          cnt[LO] <= 8'h00;
          cnt[HI] <= 8'h00;
          cap[LO] <= 8'h00;
          cap[HI] <= 8'h00;
        end else begin
          cnt[LO] <= next_lo;
          cnt[HI] <= next_hi;
          cap[LO] <= next_cap_lo;
          cap[HI] <= next_cap_hi;
        end
      end
    end
  endgenerate

  // Mode and match registers of timers 0..3
  generate
    for (t = 0; t < 4; t++) begin : g_treg
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          mode[t] <= tpw_mode_t'(`TPW_RST_BYTE);
          match[t] <= `TPW_RST_BYTE;
        end else begin
          if (acc_wr && idx == `TPW_IDX_MODE0 + 5'(t)) mode[t] <= tpw_mode_t'(wbyte);
          if (acc_wr && idx == `TPW_IDX_MATCH0 + 5'(t)) match[t] <= wbyte;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Timer 4: always 16 bits
  logic [15:0] cnt4;
  logic m4;
  assign m4 = cnt4 == match4;
  assign flag_set[4] = tick[4] & m4;

  // timer 4 capture on its trigger edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt4 <= 16'h0000;
      cap4 <= 16'h0000;
    end else if (mode[4].cap_en && trg[4]) begin
      cap4 <= cnt4;
      cnt4 <= 16'h0000;
    end else if (tick[4]) begin
      cnt4 <= m4 ? 16'h0000 : cnt4 + 16'h0001;
    end
  end

  // ==========================================================
  // PWM channels on timers 1 and 3
  tpw_pwm_cfg_t pwm_cfg [0:1];
  logic [1:0] pwm_wave;

  // two identical channels, each with its own registers
  generate
    for (p = 0; p < 2; p++) begin : g_pwm
      localparam int HT = 2 * p + 1;
      logic [4:0] base;
      assign base = 5'(p) * `TPW_IDX_PWM_STRIDE;

      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          pwm_period[p] <= `TPW_RST_BYTE;
          pwm_duty[p] <= `TPW_RST_BYTE;
          pwm_ext[p] <= 4'h0;
        end else begin
          if (acc_wr && idx == `TPW_IDX_PWM_PERIOD0 + base) pwm_period[p] <= wbyte;
          if (acc_wr && idx == `TPW_IDX_PWM_DUTY0 + base) pwm_duty[p] <= wbyte;
          if (acc_wr && idx == `TPW_IDX_PWM_EXT0 + base) pwm_ext[p] <= wbyte[3:0];
        end
      end

      // period high bits from extension 3:2
      assign pwm_cfg[p].period = {pwm_ext[p][`TPW_EXT_PERIOD_HI:`TPW_EXT_PERIOD_LO], pwm_period[p]};
      // duty high bits from extension 1:0, held until period match
      assign pwm_cfg[p].duty_hold = {pwm_ext[p][`TPW_EXT_DUTY_HI:`TPW_EXT_DUTY_LO], pwm_duty[p]};
      assign pwm_cfg[p].duty_level_invert = mode[HT].duty_level_invert;

      // channel runs only while the timer's PWM enable is set
      tpw_pwm_chan #(.W(10)) u_chan (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(mode[HT].pwm_en),
        .i_tick(tick[HT]),
        .i_cfg(pwm_cfg[p]),
        .o_pwm(pwm_wave[p])
      );
    end
  endgenerate

  // pin carries the wave only when its port-select bit is one
  assign o_pwm_pin_oe = {port_sel[`TPW_PSEL_PWM1], port_sel[`TPW_PSEL_PWM0]};
  assign o_pwm_pin = pwm_wave & o_pwm_pin_oe;

  // ==========================================================
  // Read mux; unmapped addresses read zero
  // match address returns capture while in capture mode
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `TPW_IDX_MODE4: rd_mux[7:0] = mode[4];
      `TPW_IDX_MATCH4_LO: rd_mux[7:0] = mode[4].cap_en ? cap4[7:0] : match4[7:0];
      `TPW_IDX_MATCH4_HI: rd_mux[7:0] = mode[4].cap_en ? cap4[15:8] : match4[15:8];
      `TPW_IDX_PORT_SEL: rd_mux[7:0] = port_sel;
      `TPW_IDX_EDGE_SEL: rd_mux[7:0] = edge_sel;
      `TPW_IDX_EDGE_SEL4: rd_mux[1:0] = edge_sel4;
      `TPW_IDX_FLAGS: rd_mux[4:0] = flags;
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (idx == `TPW_IDX_MODE0 + 5'(i)) rd_mux[7:0] = mode[i];
          if (idx == `TPW_IDX_MATCH0 + 5'(i)) rd_mux[7:0] = cap_mode[i] ? cap[i] : match[i];
        end
        for (int i = 0; i < 2; i++) begin
          if (idx == `TPW_IDX_PWM_PERIOD0 + 5'(i * 3)) rd_mux[7:0] = pwm_period[i];
          if (idx == `TPW_IDX_PWM_DUTY0 + 5'(i * 3)) rd_mux[7:0] = pwm_duty[i];
          if (idx == `TPW_IDX_PWM_EXT0 + 5'(i * 3)) rd_mux[3:0] = pwm_ext[i];
        end
      end
    endcase
  end

endmodule

// ===== tb/tpw_top_asserts.sv
// Bus, pin and flag properties of the timer/PWM block
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_top_asserts (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [`TPW_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [4:0] i_capture_trigger_input,
  input wire logic [2:0] i_ext_count,
  input wire logic [4:0] o_match_flag,
  input wire logic [1:0] o_pwm_pin,
  input wire logic [1:0] o_pwm_pin_oe
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  wire logic req = i_avs_read | i_avs_write;
  wire logic acc = req & ~o_avs_waitrequest;
  wire logic [4:0] idx = i_avs_address[6:2];

  chk_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("no wait state on new request");
  chk_one_wait: assert property ((req && o_avs_waitrequest) ##1 req |-> !o_avs_waitrequest)
    else $error("request not accepted after one wait");
  chk_read_upper: assert property (i_avs_read && acc |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_unmapped_zero: assert property (i_avs_read && acc && idx > 5'd20 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_pin0_gated: assert property (!o_pwm_pin_oe[0] |-> !o_pwm_pin[0])
    else $error("pwm pin 0 driven while not selected");
  chk_pin1_gated: assert property (!o_pwm_pin_oe[1] |-> !o_pwm_pin[1])
    else $error("pwm pin 1 driven while not selected");
  chk_oe_follows: assert property (i_avs_write && acc && idx == 5'd11 |=> o_pwm_pin_oe == $past(i_avs_writedata[1:0]))
    else $error("pin enable not taken from port select");
  chk_flag_clear: assert property ((($past(o_match_flag) & ~o_match_flag) != 5'h0)
      |-> $past(i_avs_write && acc && idx == 5'd14))
    else $error("match flag dropped without clear");

  cover property (o_pwm_pin[0] ##1 !o_pwm_pin[0]);
  cover property ($rose(o_pwm_pin[1]));
  cover property ($rose(o_match_flag[2]));
endmodule

bind tpw_top tpw_top_asserts u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_capture_trigger_input(i_capture_trigger_input), .i_ext_count(i_ext_count),
  .o_match_flag(o_match_flag), .o_pwm_pin(o_pwm_pin), .o_pwm_pin_oe(o_pwm_pin_oe));

// ===== tb/tpw_load_model.sv
// Load on the PWM pins and source of capture and count edges
`timescale 1ns/1ps
module tpw_load_model (
  input wire logic i_sys_clk,
  input wire logic [1:0] i_pwm_pin,
  output logic [4:0] o_capture_trigger_input,
  output logic [2:0] o_ext_count
);
  // ==========================================================
  // Sources idle low
  initial begin
    o_capture_trigger_input = 5'h00;
    o_ext_count = 3'h0;
  end

  // Trigger held three clocks so a synchronised edge is seen once
  task automatic edge_trig(input int k);
    @(posedge i_sys_clk);
    o_capture_trigger_input[k] <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    o_capture_trigger_input[k] <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask

  // Count pulses, two clocks high and two low
  task automatic ext_pulses(input int k, input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_ext_count[k] <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      o_ext_count[k] <= 1'b0;
      @(posedge i_sys_clk);
    end
  endtask

  // High time and period of one full pulse, in clocks; bounded waits
  task automatic measure(input int ch, output int hi, output int per);
    int n;
    n = 0;
    while (i_pwm_pin[ch] !== 1'b0 && n < 3000) begin
      @(posedge i_sys_clk);
      n++;
    end
    while (i_pwm_pin[ch] !== 1'b1 && n < 6000) begin
      @(posedge i_sys_clk);
      n++;
    end
    hi = 0;
    while (i_pwm_pin[ch] === 1'b1 && hi < 3000) begin
      @(posedge i_sys_clk);
      hi++;
    end
    per = hi;
    while (i_pwm_pin[ch] !== 1'b1 && per < 6000) begin
      @(posedge i_sys_clk);
      per++;
    end
  endtask

  // Clocks at high level over a window
  task automatic count_high(input int ch, input int win, output int hi);
    hi = 0;
    repeat (win) begin
      @(posedge i_sys_clk);
      if (i_pwm_pin[ch] === 1'b1) hi++;
    end
  endtask
endmodule

// ===== tb/test_timer_pwm_and_wide_capture.sv
// Self-checking testbench of the timer/PWM block
`timescale 1ns/1ps
`include "tpw_regs.svh"
module test_timer_pwm_and_wide_capture;
  import tpw_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [`TPW_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] trig;
  logic [2:0] ext_count;
  logic [4:0] match_flag;
  logic [1:0] pwm_pin;
  logic [1:0] pwm_pin_oe;
  logic [31:0] rd;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int hi, per;

  // ==========================================================
  // Clock, design and far side
  always #5 sys_clk = ~sys_clk;

  tpw_top dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_capture_trigger_input(trig), .i_ext_count(ext_count),
    .o_match_flag(match_flag), .o_pwm_pin(pwm_pin), .o_pwm_pin_oe(pwm_pin_oe));
  tpw_load_model load (.i_sys_clk(sys_clk), .i_pwm_pin(pwm_pin), .o_capture_trigger_input(trig),
    .o_ext_count(ext_count));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; the hang guard ends a stuck wait
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check(n, 2, "bus wait states");
  endtask

  task automatic rdchk(input logic [4:0] idx, input logic [31:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    check(rd, exp, what);
  endtask

  // count stopped while period and duty load, extension byte written last
  task automatic pwm_setup(input int ch, input logic [7:0] mode, input logic [9:0] p, input logic [9:0] d);
    logic [4:0] base;
    base = 5'(15 + 3 * ch);
    bus(1'b1, 5'(1 + 2 * ch), mode & 8'hf7);
    bus(1'b1, base, p[7:0]);
    bus(1'b1, base + 5'd1, d[7:0]);
    bus(1'b1, base + 5'd2, {4'h0, p[9:8], d[9:8]});
    bus(1'b1, 5'(1 + 2 * ch), mode);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    check(pwm_pin_oe, 2'b00, "oe after reset");
    check(match_flag, 5'h00, "flags after reset");
    rdchk(5'd0, 32'h0, "mode after reset");
    bus(1'b1, 5'd31, 8'haa);
    rdchk(5'd31, 32'h0, "unmapped read");
    bus(1'b1, 5'd11, 8'h03);
    // Select lands on the accept edge, look one clock later
    @(posedge sys_clk);
    check(pwm_pin_oe, 2'b11, "oe after select");
    $display("Test reset done");
  endtask

  // Shape per channel and polarity, source tick is two clocks
  task automatic test_pwm_shape();
    int chs[4] = '{0, 1, 1, 0};
    logic [7:0] modes[4] = '{8'hc8, 8'hc8, 8'h48, 8'h48};
    logic [9:0] ps[4] = '{10'h200, 10'd10, 10'd10, 10'd40};
    logic [9:0] ds[4] = '{10'h110, 10'd4, 10'd4, 10'd15};
    for (int i = 0; i < 4; i++) begin
      pwm_setup(chs[i], modes[i], ps[i], ds[i]);
      load.measure(chs[i], hi, per);
      load.measure(chs[i], hi, per);
      check(per, 2 * ps[i], "pwm period");
      check(hi, modes[i][7] ? 2 * ds[i] : 2 * (ps[i] - ds[i]), "pwm high time");
    end
    $display("Test pwm shape done");
  endtask

  // Duty equal to period and duty 100h give steady levels
  task automatic test_pwm_limits();
    logic [7:0] modes[4] = '{8'hc8, 8'h48, 8'hc8, 8'h48};
    logic [9:0] ds[4] = '{10'h120, 10'h120, `TPW_DUTY_FORCE_OFF, `TPW_DUTY_FORCE_OFF};
    int exp[4] = '{600, 0, 0, 600};
    for (int i = 0; i < 4; i++) begin
      pwm_setup(1, modes[i], 10'h120, ds[i]);
      repeat (700) @(posedge sys_clk);
      load.count_high(1, 600, hi);
      check(hi, exp[i], "steady level");
    end
    $display("Test pwm limits done");
  endtask

  // Duty written in mid-pulse waits for the period end
  task automatic test_duty_buffer();
    pwm_setup(0, 8'hc8, 10'd20, 10'd5);
    load.measure(0, hi, per);
    fork
      load.measure(0, hi, per);
      begin
        @(posedge pwm_pin[0]);
        bus(1'b1, 5'd16, 8'd12);
      end
    join
    check(hi, 10, "old duty kept");
    load.measure(0, hi, per);
    check(hi, 24, "new duty");
    bus(1'b1, 5'd15, 8'd40);
    load.measure(0, hi, per);
    load.measure(0, hi, per);
    check(hi, 24, "duty time after period change");
    check(per, 80, "changed period");
    $display("Test duty buffer done");
  endtask

  // pair k joins timers 2k and 2k+1 counting external edges
  task automatic test_wide_capture(input int k);
    bus(1'b1, 5'(4 + 2 * k), 8'hff);
    bus(1'b1, 5'(5 + 2 * k), 8'hff);
    bus(1'b1, 5'd12, k ? 8'hdf : 8'hfd);
    bus(1'b1, 5'(1 + 2 * k), 8'h33);
    bus(1'b1, 5'(2 * k), 8'h1f);
    load.edge_trig(2 * k);
    load.ext_pulses(k, 300);
    load.edge_trig(2 * k);
    rdchk(5'(4 + 2 * k), 32'h2c, "wide low byte");
    rdchk(5'(5 + 2 * k), 32'h01, "wide high byte");
    bus(1'b1, 5'(2 * k), 8'h00);
    bus(1'b1, 5'(1 + 2 * k), 8'h00);
    $display("Test wide capture done");
  endtask

  task automatic test_t4_capture();
    bus(1'b1, 5'd9, 8'hff);
    bus(1'b1, 5'd10, 8'hff);
    bus(1'b1, 5'd13, 8'h01);
    bus(1'b1, 5'd8, 8'h1f);
    load.edge_trig(4);
    load.ext_pulses(2, 5);
    load.edge_trig(4);
    rdchk(5'd9, 32'h05, "timer4 capture low");
    rdchk(5'd10, 32'h00, "timer4 capture high");
    $display("Test timer4 capture done");
  endtask

  task automatic test_match_flag();
    bus(1'b1, 5'd12, 8'hff);
    bus(1'b1, 5'd6, 8'h03);
    bus(1'b1, 5'd2, 8'h0f);
    load.ext_pulses(1, 3);
    check(match_flag, 5'h00, "flag before match");
    load.ext_pulses(1, 1);
    check(match_flag, 5'h04, "flag at match");
    rdchk(5'd14, 32'h04, "flag register");
    bus(1'b1, 5'd14, 8'h04);
    @(posedge sys_clk);
    check(match_flag, 5'h00, "flag cleared");
    $display("Test match flag done");
  endtask

  // ==========================================================
  // Verdict and run control
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    test_reset();
    test_pwm_shape();
    test_pwm_limits();
    test_duty_buffer();
    test_wide_capture(0);
    test_wide_capture(1);
    test_t4_capture();
    test_match_flag();
    finish_test();
  end
endmodule
